// ===== core/drr_pkg.sv
package drr_pkg;
    // register map, byte addresses on the plain register port
    localparam logic [7:0] CFG_OFS     = 8'h00;
    localparam logic [7:0] STAT_OFS    = 8'h04;
    localparam logic [31:0] CFG_RST    = 32'h0000_0000;
    // config word fields
    localparam int         TCR_EN_BIT  = 0;
    localparam int         TCR_EXT_BIT = 1;
    localparam int         GRAN_LSB    = 6;
    // status word fields
    localparam int         ST_BUSY     = 0;
    localparam int         ST_RATE_LSB = 1;
    localparam int         ST_CNT_LSB  = 3;
    localparam int         ST_READY    = 5;
    localparam int         ST_BADCODE  = 6;
    localparam int         ST_EARLY    = 7;
    // refresh granularity field codes
    localparam logic [2:0] GRAN_FIX1   = 3'h0;
    localparam logic [2:0] GRAN_FIX2   = 3'h1;
    localparam logic [2:0] GRAN_FIX4   = 3'h2;
    localparam logic [2:0] GRAN_OTF12  = 3'h5;
    localparam logic [2:0] GRAN_OTF14  = 3'h6;
    // case temperature thresholds, degrees C
    localparam logic [7:0] TEMP_LOW_C  = 8'h2D;
    localparam logic [7:0] TEMP_HOT_C  = 8'h55;
    // clock and refresh cycle times
    localparam int         CLK_PS      = 20000;
    localparam int         RFC1_NS     = 260;
    localparam int         RFC2_NS     = 160;
    localparam int         RFC4_NS     = 110;
    localparam int         RFC1_CYC    = (RFC1_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int         RFC2_CYC    = (RFC2_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int         RFC4_CYC    = (RFC4_NS * 1000 + CLK_PS - 1) / CLK_PS;

    typedef enum logic [1:0] {RATE_1X, RATE_2X, RATE_4X} drr_rate_t;
endpackage

// ===== core/drr_refresh_ctrl.sv
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
// How it works
// - extended-range temperature control, normal temperature: execute every second refresh
// - extended-range temperature control, below 45C: execute one refresh in four
// - granularity field codes select fixed or per-command modes
// - per-command modes: group bit zero picks rate
// - refresh decoded from five command pins
// - busy 260, 160 or 120 ns (110 ns rounded up to 20 ns cycles)
// - each refresh timed by its own rate
// - same rate mode switch is no change
module drr_refresh_ctrl
    import drr_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // command pins
    input  wire logic        cs_n,
    input  wire logic        act_n,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic        group_select_bit_zero,
    // case temperature, degrees C
    input  wire logic [7:0]  temp_case,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // internal refresh engine
    output logic             int_refresh,
    output drr_pkg::drr_rate_t int_rate,
    output logic             refresh_busy
);
    import drr_pkg::*;

    logic [2:0] refresh_granularity_field_q;
    logic       temp_controlled_refresh_q;
    logic       tcr_ext_q;
    logic       bad_code_q;
    logic       early_q;
    logic       busy_q;
    logic [3:0] busy_cnt_q;
    logic [1:0] gear_q;
    logic [1:0] sub_cnt_q;
    logic       int_ref_q;
    drr_rate_t  int_rate_q;
    drr_rate_t  last_rate_q;
    logic [31:0] rdata_q;

    logic       ref_cmd;
    logic       ref_take;
    drr_rate_t  cmd_rate;
    drr_rate_t  mode_rate;
    drr_rate_t  new_rate;
    logic       gran_legal;
    logic       cfg_wr;
    logic       rate_change;
    logic       gear_exec;
    logic       cnt_ready;
    logic [3:0] busy_load;

    assign ref_cmd  = !cs_n && act_n && !ras_n && !cas_n && we_n;
    // refresh during an unfinished cycle is dropped and flagged
    assign ref_take = ref_cmd && !busy_q;
    assign cfg_wr   = reg_wr && reg_addr == CFG_OFS;

    function automatic drr_rate_t mode_of(input logic [2:0] g);
        drr_rate_t r;
        r = RATE_1X;
        if (g == GRAN_FIX2 || g == GRAN_OTF12) begin
            r = RATE_2X;
        end else if (g == GRAN_FIX4 || g == GRAN_OTF14) begin
            r = RATE_4X;
        end
        return r;
    endfunction

    always_comb begin
        mode_rate = mode_of(refresh_granularity_field_q);
        cmd_rate  = mode_rate;
        if (refresh_granularity_field_q[2]) begin
            cmd_rate = group_select_bit_zero ? mode_rate : RATE_1X;
        end
    end

    assign new_rate   = mode_of(reg_wdata[GRAN_LSB +: 3]);
    assign gran_legal = reg_wdata[GRAN_LSB +: 3] inside
        {GRAN_FIX1, GRAN_FIX2, GRAN_FIX4, GRAN_OTF12, GRAN_OTF14};
    // fixed/per-command swap at one rate leaves the count alone
    assign rate_change = cfg_wr && gran_legal && new_rate != mode_rate;

    always_comb begin
        unique case (cmd_rate)
            RATE_1X: busy_load = 4'(RFC1_CYC);
            RATE_2X: busy_load = 4'(RFC2_CYC);
            RATE_4X: busy_load = 4'(RFC4_CYC);
            default: busy_load = 4'(RFC1_CYC);
        endcase
    end

    // gear only in extended-range temperature control
    always_comb begin
        gear_exec = 1'b1;
        if (temp_controlled_refresh_q && tcr_ext_q
                && temp_case < TEMP_HOT_C) begin
            if (temp_case < TEMP_LOW_C) begin
                gear_exec = gear_q == 2'h0;
            end else begin
                gear_exec = !gear_q[0];
            end
        end
    end

    assign cnt_ready = (mode_rate == RATE_1X)
        || (mode_rate == RATE_2X && !sub_cnt_q[0])
        || (mode_rate == RATE_4X && sub_cnt_q == 2'h0);

    // configuration; a reserved code keeps the old field
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            refresh_granularity_field_q <= CFG_RST[GRAN_LSB +: 3];
            temp_controlled_refresh_q   <= CFG_RST[TCR_EN_BIT];
            tcr_ext_q                   <= CFG_RST[TCR_EXT_BIT];
        end else if (cfg_wr) begin
            temp_controlled_refresh_q <= reg_wdata[TCR_EN_BIT];
            tcr_ext_q                 <= reg_wdata[TCR_EXT_BIT];
            if (gran_legal) begin
                refresh_granularity_field_q <= reg_wdata[GRAN_LSB +: 3];
            end
        end
    end

    // sticky flags, set beats write-one clear
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bad_code_q <= 1'b0;
            early_q    <= 1'b0;
        end else begin
            if (cfg_wr && !gran_legal) begin
                bad_code_q <= 1'b1;
            end else if (reg_wr && reg_addr == STAT_OFS
                    && reg_wdata[ST_BADCODE]) begin
                bad_code_q <= 1'b0;
            end
            if (ref_cmd && busy_q) begin
                early_q <= 1'b1;
            end else if (reg_wr && reg_addr == STAT_OFS
                    && reg_wdata[ST_EARLY]) begin
                early_q <= 1'b0;
            end
        end
    end

    // refresh cycle timer, loaded by the rate of this very command
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            busy_q     <= 1'b0;
            busy_cnt_q <= 4'h0;
        end else if (ref_take) begin
            busy_q     <= 1'b1;
            busy_cnt_q <= busy_load;
        end else if (busy_q) begin
            busy_cnt_q <= busy_cnt_q - 4'h1;
            if (busy_cnt_q == 4'h1) begin
                busy_q <= 1'b0;
            end
        end
    end

    // gear ratio counter and internal refresh strobe
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gear_q     <= 2'h0;
            int_ref_q  <= 1'b0;
            int_rate_q <= RATE_1X;
        end else begin
            int_ref_q <= ref_take && gear_exec;
            if (ref_take) begin
                gear_q     <= gear_q + 2'h1;
                int_rate_q <= cmd_rate;
            end
        end
    end

    // sub-rate refresh count since last 1x or rate change
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sub_cnt_q   <= 2'h0;
            last_rate_q <= RATE_1X;
        end else if (rate_change) begin
            sub_cnt_q <= 2'h0;
        end else if (ref_take) begin
            last_rate_q <= cmd_rate;
            if (cmd_rate == RATE_1X) begin
                sub_cnt_q <= 2'h0;
            end else begin
                sub_cnt_q <= sub_cnt_q + 2'h1;
            end
        end
    end

    // read data stands one cycle after the strobe
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            rdata_q <= 32'h0000_0000;
            if (reg_addr == CFG_OFS) begin
                rdata_q[GRAN_LSB +: 3]  <= refresh_granularity_field_q;
                rdata_q[TCR_EN_BIT]     <= temp_controlled_refresh_q;
                rdata_q[TCR_EXT_BIT]    <= tcr_ext_q;
            end else if (reg_addr == STAT_OFS) begin
                rdata_q[ST_BUSY]            <= busy_q;
                rdata_q[ST_RATE_LSB +: 2]   <= last_rate_q;
                rdata_q[ST_CNT_LSB +: 2]    <= sub_cnt_q;
                rdata_q[ST_READY]           <= cnt_ready;
                rdata_q[ST_BADCODE]         <= bad_code_q;
                rdata_q[ST_EARLY]           <= early_q;
            end
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign reg_rdata    = rdata_q;
    assign int_refresh  = int_ref_q;
    assign int_rate     = int_rate_q;
    assign refresh_busy = busy_q;

    sequence s_busy_run8;
        busy_q [*8];
    endsequence

    a_decode_take: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!cs_n && act_n && !ras_n && !cas_n && we_n && !busy_q)
        |=> busy_q) else $error("refresh command not taken");
    a_busy_1x_len: assert property (@(posedge ref_clk) disable iff (!nrst)
        ref_take && cmd_rate == RATE_1X |=>
        s_busy_run8 ##1 busy_q [*5] ##1 !busy_q)
        else $error("1x cycle time wrong");
    a_busy_2x_len: assert property (@(posedge ref_clk) disable iff (!nrst)
        ref_take && cmd_rate == RATE_2X |=> s_busy_run8 ##1 !busy_q)
        else $error("2x cycle time wrong");
    a_busy_4x_len: assert property (@(posedge ref_clk) disable iff (!nrst)
        ref_take && cmd_rate == RATE_4X |=> busy_q [*6] ##1 !busy_q)
        else $error("4x cycle time wrong");
    a_otf_low_1x: assert property (@(posedge ref_clk) disable iff (!nrst)
        ref_take && refresh_granularity_field_q[2]
        && !group_select_bit_zero |=> int_rate_q == RATE_1X)
        else $error("per-command low bit not 1x");
    a_fixed_rate: assert property (@(posedge ref_clk) disable iff (!nrst)
        ref_take && refresh_granularity_field_q == GRAN_FIX4
        |=> int_rate_q == RATE_4X)
        else $error("fixed 4x rate not used");
    a_reserved_kept: assert property (@(posedge ref_clk) disable iff (!nrst)
        cfg_wr && !gran_legal |=> $stable(refresh_granularity_field_q)
        && bad_code_q) else $error("reserved code accepted");
    a_gear_half: assert property (@(posedge ref_clk) disable iff (!nrst)
        ref_take && temp_controlled_refresh_q && tcr_ext_q
        && temp_case >= TEMP_LOW_C && temp_case < TEMP_HOT_C && gear_q[0]
        |=> !int_ref_q) else $error("gear did not skip");
    a_gear_cold: assert property (@(posedge ref_clk) disable iff (!nrst)
        ref_take && temp_controlled_refresh_q && tcr_ext_q
        && temp_case < TEMP_LOW_C && gear_q != 2'h0
        |=> !int_ref_q) else $error("cold gear did not skip");
    a_same_rate_swap: assert property (@(posedge ref_clk) disable iff (!nrst)
        cfg_wr && gran_legal && new_rate == mode_rate && !ref_take
        |=> $stable(sub_cnt_q)) else $error("swap reset count");
endmodule

// ===== verification/drr_ctl_model.sv
`timescale 1ns/1ps
module drr_ctl_model (
    // clock, reset, device busy
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic busy,
    // command pins
    output logic      cs_n,
    output logic      act_n,
    output logic      ras_n,
    output logic      cas_n,
    output logic      we_n,
    output logic      group_select_bit_zero
);
    logic sel = 1'b0;
    logic bg  = 1'b0;
    logic junk_q;

    // unselected pins wander so a stale level is never trusted
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) junk_q <= 1'b0;
        else junk_q <= ~junk_q;
    end

    assign cs_n  = ~sel;
    assign act_n = sel | junk_q;
    assign ras_n = ~sel & junk_q;
    assign cas_n = ~sel & ~junk_q;
    assign we_n  = sel | ~junk_q;
    assign group_select_bit_zero = sel ? bg : junk_q;

    // hurry breaks the deselect window on purpose
    task automatic issue(input logic b0, input logic hurry);
        int n;
        n = 0;
        if (hurry) @(posedge ref_clk);
        while (busy !== 1'b0 && !hurry && n < 60) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        sel <= 1'b1;
        bg  <= b0;
        @(posedge ref_clk);
        sel <= 1'b0;
    endtask
endmodule

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
    import drr_pkg::*;
    logic        ref_clk   = 1'b0;
    logic        nrst      = 1'b0;
    logic        cs_n, act_n, ras_n, cas_n, we_n, bit0;
    logic [7:0]  temp_case = 8'h19;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] reg_rdata, rv;
    logic        int_refresh, refresh_busy;
    drr_rate_t   int_rate;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          pulses, k;
    integer      seed = 32'h0cc5297e;
    logic [1:0]  cnt;
    logic [2:0]  gran;
    logic        ext = 1'b0;
    // 7.8us base refresh interval in 20ns cycles
    localparam int BASE_IVL_CYC = 390;
    logic [2:0]  modes [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    logic [2:0]  bad [3]   = '{3'h3, 3'h4, 3'h7};
    logic [7:0]  t_lo [7]  = '{8'h55, 8'h2D, 8'h0, 8'h0, 8'h55, 8'h2D, 8'h2C};
    logic [7:0]  t_sp [7]  = '{8'h0B, 8'h28, 8'h2D, 8'h2D, 8'h1, 8'h1, 8'h1};

    initial forever #10 ref_clk = ~ref_clk;

    drr_refresh_ctrl i_drr_refresh_ctrl (
        .ref_clk(ref_clk), .nrst(nrst), .cs_n(cs_n), .act_n(act_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .group_select_bit_zero(bit0), .temp_case(temp_case),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_refresh(int_refresh),
        .int_rate(int_rate), .refresh_busy(refresh_busy));
    drr_ctl_model i_drr_ctl_model (
        .ref_clk(ref_clk), .nrst(nrst), .busy(refresh_busy), .cs_n(cs_n),
        .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .group_select_bit_zero(bit0));

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    function automatic drr_rate_t exp_rate(input logic [2:0] g, input logic b);
        case (g)
            GRAN_FIX2:  return RATE_2X;
            GRAN_FIX4:  return RATE_4X;
            GRAN_OTF12: return b ? RATE_2X : RATE_1X;
            GRAN_OTF14: return b ? RATE_4X : RATE_1X;
            default:    return RATE_1X;
        endcase
    endfunction

    function automatic logic exp_ready(input logic [2:0] g,
                                       input logic [1:0] c);
        if (g == GRAN_FIX2 || g == GRAN_OTF12) return !c[0];
        if (g == GRAN_FIX4 || g == GRAN_OTF14) return c == 2'h0;
        return 1'b1;
    endfunction

    // extended range or a hot case halves the period once more
    function automatic int exp_ivl(input drr_rate_t r);
        int sh;
        sh = int'(r) + ((ext || temp_case > TEMP_HOT_C) ? 1 : 0);
        return BASE_IVL_CYC >> sh;
    endfunction

    task automatic do_ref(input logic b);
        drr_rate_t r;
        int        nb;
        r  = exp_rate(gran, b);
        nb = 0;
        i_drr_ctl_model.issue(b, 1'b0);
        #1;
        // the executed pulse stands only in the cycle after the command
        pulses += (int_refresh === 1'b1);
        do begin
            @(posedge ref_clk);
            #1;
            pulses += (int_refresh === 1'b1);
            nb++;
        end while (refresh_busy === 1'b1 && nb < 40);
        chk("busy cycles", (r == RATE_1X ? RFC1_CYC : r == RATE_2X ?
            RFC2_CYC : RFC4_CYC), nb);
        chk("rate", 32'(r), 32'(int_rate));
        cnt = (r == RATE_1X) ? 2'h0 : cnt + 2'h1;
        rd(STAT_OFS, rv);
        chk("status", 32'({exp_ready(gran, cnt), cnt, 2'(r), 1'b0}),
            32'(rv[5:0]));
        // next command one full refresh period after this one
        repeat (exp_ivl(r) - nb - 2) @(posedge ref_clk);
    endtask

    initial begin
        #1800000;
        n_mismatch++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        gran = GRAN_FIX1;
        cnt = 2'h0;
        wr(8'h08, 32'hFFFF_FFFF);
        rd(CFG_OFS, rv);
        chk("cfg reset", CFG_RST, rv);
        rd(8'h08, rv);
        chk("unmapped", 32'h0, rv);
        rd(STAT_OFS, rv);
        chk("status reset", 32'h20, rv);
        $display("test reset done");
        foreach (modes[m]) begin
            gran = modes[m];
            wr(CFG_OFS, 32'(gran) << GRAN_LSB);
            rd(CFG_OFS, rv);
            chk("cfg", 32'(gran) << GRAN_LSB, rv);
            if (gran[2]) begin
                for (k = 0; k < 2; k++) begin
                    if (k == 0 || 1'($random(seed)))
                        repeat (gran == GRAN_OTF12 ? 2 : 4)
                            do_ref(1'b1);
                    do_ref(1'b0);
                end
            end else begin
                repeat (4) do_ref(1'($random(seed)));
            end
        end
        gran = GRAN_FIX2;
        wr(CFG_OFS, 32'(gran) << GRAN_LSB);
        do_ref(1'b0);
        gran = GRAN_OTF12;
        wr(CFG_OFS, 32'(gran) << GRAN_LSB);
        rd(STAT_OFS, rv);
        chk("swap count", 32'h0A, 32'(rv[5:0]));
        do_ref(1'b1);
        $display("test modes done");
        i_drr_ctl_model.issue(1'b0, 1'b0);
        i_drr_ctl_model.issue(1'b0, 1'b1);
        for (k = 0; k < 40 && refresh_busy !== 1'b0; k++) begin
            @(posedge ref_clk);
            #1;
        end
        chk("busy end", 32'h0, 32'(refresh_busy));
        rd(STAT_OFS, rv);
        chk("early flag", 32'h1, 32'(rv[7]));
        wr(STAT_OFS, 32'h80);
        rd(STAT_OFS, rv);
        chk("early clear", 32'h0, 32'(rv[7]));
        $display("test early done");
        foreach (bad[i]) begin
            wr(CFG_OFS, 32'(bad[i]) << GRAN_LSB);
            rd(CFG_OFS, rv);
            chk("cfg kept", 32'(gran) << GRAN_LSB, rv);
            rd(STAT_OFS, rv);
            chk("bad code", 32'h1, 32'(rv[6]));
            wr(STAT_OFS, 32'h40);
        end
        rd(STAT_OFS, rv);
        chk("bad clear", 32'h0, 32'(rv[6]));
        $display("test reserved done");
        gran = GRAN_FIX1;
        for (k = 0; k < 7; k++) begin
            temp_case <= t_lo[k] + 8'($unsigned($random(seed)) % t_sp[k]);
            ext = (k != 3);
            wr(CFG_OFS, ext ? 32'h3 : 32'h1);
            pulses = 0;
            repeat (4) do_ref(1'($random(seed)));
            chk("executed", (k == 3 || temp_case >= TEMP_HOT_C) ? 4 :
                (temp_case >= TEMP_LOW_C) ? 2 : 1, pulses);
        end
        $display("test gear done");
        conclude();
    end
endmodule
